// ---- src/parallel_flash_programming_port.sv ----
// Parallel flash programming port: handshake engine, field latch, request
// FIFO towards the flash executor, and external clock presence detection.
// Assumes pull-ups on every port pin outside the chip and a flash executor
// that drains requests and answers reads with rd_valid/rd_data.
// Function
// - Field 0 command, 1 low address, 2 next address byte, 5 data; others none.
// - Command field stores the latched word as the pending command.
// - 0x0011 read, 0x0012 write page, 0x0022 write page and lock.
// - 0x0032 erase then write, 0x0042 erase, write, then lock.
// - 0x0013 erase all, 0x0014/0x0024 set/clear lock, 0x0015 read lock.
// - GP bits 0x0034/0x0044/0x0025; security set 0x0054, read 0x0035.
// - 0x001F write memory, 0x0016 select controller, 0x001E version.
// - Use external clock if above 32 kHz, decided before first ready drop.
// - Selector and data set before strobe; device latches them on strobe low.
// - Device drops ready after latching; programmer holds inputs until then.
// - With ready low device executes and polls for strobe high.
// - Ready rises only after strobe high and execution done.
// - At reset every port pin is an input with pull-up.
// - Read drives bus after output enable low, then valid; releases on high.
// - Data handshakes in read or page-write commands advance the address.
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO, flip-flop storage
module ffpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_s;
  fifo_s s_q, s_d;
  logic  push, pop;

  // Honest full and empty straight from the count
  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module parallel_flash_programming_port
  import ffpi_pkg::*;
#(
  parameter int EXT_DETECT = ffpi_pkg::EXT_DETECT_CYCLES,
  parameter int DEPTH      = ffpi_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Mode straps and external clock
  input  wire logic             test_select,
  input  wire logic             prog_select_a,
  input  wire logic             prog_select_b,
  input  wire logic             ext_clock_in,
  // Programmer pins
  input  wire logic             cmd_strobe_n,
  input  wire logic             read_out_enable_n,
  input  wire logic [3:0]       field_select,
  input  wire logic [15:0]      prog_data_bus_in,
  output logic [15:0]           prog_data_bus_out,
  output logic                  prog_data_bus_oe,
  output logic                  port_ready,
  output logic                  port_ready_oe,
  output logic                  bus_drive_valid_n,
  output logic                  bus_drive_valid_n_oe,
  // Clock source choice
  output logic                  ext_clock_select,
  // Flash executor side
  output logic                  req_valid,
  input  wire logic             req_ready,
  output ffpi_pkg::req_s        req,
  input  wire logic             rd_valid,
  input  wire logic [15:0]      rd_data
);
  import ffpi_pkg::*;
  localparam int GW = $clog2(EXT_DETECT + 1);

  typedef struct packed {
    hs_state_e     st;
    logic [3:0]    sel;
    logic [15:0]   cmd;
    logic [31:0]   addr;
    logic [15:0]   data;
    logic [15:0]   rdata;
    logic          drive;
    logic          valid_n;
    logic [1:0]    strobe_sync;
    logic [1:0]    oe_sync;
    logic [2:0]    xin_sync;
    logic [GW-1:0] gap;
    logic          seen_edge;
    logic          ext_fast;
    logic          ext_sel;
    logic          clk_locked;
    logic          live;
  } core_s;
  core_s s_q, s_d;

  logic prog_mode, strobe_s, oe_s, xin_rise, fifo_in_ready, push_ok;
  req_s push_req;

  // Read-type commands answer over the data bus
  function automatic logic is_read_cmd(input logic [15:0] c);
    return (c == READ_FLASH_CMD) || (c == GET_LOCK_BITS_CMD) ||
           (c == GET_GP_NVM_CMD) || (c == GET_SECURITY_CMD) ||
           (c == GET_VERSION_CMD);
  endfunction

  // Commands whose data handshakes walk the address
  function automatic logic is_stream_cmd(input logic [15:0] c);
    return (c == READ_FLASH_CMD) || (c == WRITE_PAGE_CMD) ||
           (c == WRITE_PAGE_LOCK_CMD) || (c == ERASE_WRITE_PAGE_CMD) ||
           (c == ERASE_WRITE_PAGE_LOCK_CMD);
  endfunction

  // Second sync stage, plus third for the clock edge; first stage feeds nothing else
  assign strobe_s  = s_q.strobe_sync[1];
  assign oe_s      = s_q.oe_sync[1];
  assign xin_rise  = s_q.xin_sync[1] && !s_q.xin_sync[2];
  assign prog_mode = test_select && prog_select_a && prog_select_b;
  assign push_req  = '{field: s_q.sel, cmd: s_q.cmd, addr: s_q.addr,
                       data: s_q.data};
  assign push_ok   = (s_q.st == ST_PUSH) && fifo_in_ready;

  // Next state of the whole port
  always_comb begin
    s_d = s_q;
    s_d.live        = 1'b1; // Pins may drive only once out of reset
    s_d.strobe_sync = {s_q.strobe_sync[0], cmd_strobe_n};
    s_d.oe_sync     = {s_q.oe_sync[0], read_out_enable_n};
    s_d.xin_sync    = {s_q.xin_sync[1:0], ext_clock_in};
    // Clock presence: a rising edge no later than the slowest period
    if (xin_rise) begin
      s_d.ext_fast  = s_q.seen_edge && (s_q.gap < GW'(EXT_DETECT));
      s_d.seen_edge = 1'b1;
      s_d.gap       = '0;
    end else if (s_q.gap != GW'(EXT_DETECT)) begin
      s_d.gap = s_q.gap + GW'(1);
    end else begin
      s_d.ext_fast = 1'b0; // Too slow or tied low: ignored
    end
    if (!s_q.clk_locked) begin
      s_d.ext_sel = s_q.ext_fast; // Frozen once ready first drops
    end
    case (s_q.st)
      ST_IDLE: begin
        // Starts only while ready high, strobe low
        if (prog_mode && !strobe_s) begin
          s_d.sel        = field_select;
          s_d.data       = prog_data_bus_in;
          s_d.clk_locked = 1'b1;
          s_d.st         = ST_WAIT_HI;
          case (field_select)
            FIELD_COMMAND: begin
              s_d.cmd = prog_data_bus_in;
              s_d.st  = ST_PUSH;
            end
            FIELD_ADDRESS_LOW: begin
              s_d.addr[ADDR_LOW_LSB +: 16] = prog_data_bus_in;
            end
            FIELD_ADDRESS_NEXT: begin
              s_d.addr[ADDR_NEXT_LSB +: 8] = prog_data_bus_in[7:0];
            end
            FIELD_DATA: begin
              s_d.st = ST_PUSH;
            end
            default: begin
              s_d.st = ST_WAIT_HI; // Selects nothing
            end
          endcase
        end
      end
      ST_PUSH: begin
        // Execution done once the executor queue takes the word
        if (fifo_in_ready) begin
          if (s_q.sel == FIELD_DATA && is_stream_cmd(s_q.cmd)) begin
            s_d.addr = s_q.addr + ADDRESS_STEP;
          end
          if (s_q.sel == FIELD_DATA && is_read_cmd(s_q.cmd)) begin
            s_d.st = ST_RD_DATA;
          end else begin
            s_d.st = ST_WAIT_HI;
          end
        end
      end
      ST_RD_DATA: begin
        if (rd_valid) begin
          s_d.rdata = rd_data;
          s_d.st    = ST_RD_OE;
        end
      end
      ST_RD_OE: begin
        // Bus stays input until output enable falls
        if (!oe_s) begin
          s_d.drive = 1'b1;
          s_d.st    = ST_RD_DRV;
        end
      end
      ST_RD_DRV: begin
        s_d.valid_n = 1'b0; // Data already stable one cycle
        if (oe_s) begin
          s_d.drive   = 1'b0;
          s_d.valid_n = 1'b1;
          s_d.st      = ST_WAIT_HI;
        end
      end
      ST_WAIT_HI: begin
        // Poll for strobe high before raising ready
        if (strobe_s) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q             <= '0;
      s_q.st          <= ST_IDLE;
      s_q.addr        <= ADDRESS_RESET;
      s_q.valid_n     <= 1'b1;
      s_q.strobe_sync <= 2'h3;
      s_q.oe_sync     <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // Queue towards the flash executor; a stall holds ready low
  ffpi_fifo #(.WIDTH($bits(req_s)), .DEPTH(DEPTH)) u_req_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (s_q.st == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (push_req),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (req)
  );

  // Pins stay inputs outside programming mode and in reset
  assign port_ready           = (s_q.st == ST_IDLE);
  assign port_ready_oe        = prog_mode && s_q.live;
  assign bus_drive_valid_n    = s_q.valid_n;
  assign bus_drive_valid_n_oe = prog_mode && s_q.live;
  assign prog_data_bus_out    = s_q.rdata;
  assign prog_data_bus_oe     = prog_mode && s_q.drive;
  assign ext_clock_select     = s_q.ext_sel;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_READY_DROP: assert property (
    (s_q.st == ST_IDLE && prog_mode && !strobe_s) |=> !port_ready)
    else $error("ready not dropped after latch");
  AST_CMD_STORE: assert property (
    (s_q.st == ST_IDLE && prog_mode && !strobe_s &&
     field_select == FIELD_COMMAND) |=> s_q.cmd == $past(prog_data_bus_in))
    else $error("command word not stored");
  AST_READY_RISE: assert property (
    $rose(port_ready) |-> $past(strobe_s) && $past(s_q.st == ST_WAIT_HI))
    else $error("ready rose before strobe high");
  AST_DRIVE_AFTER_OE: assert property (
    $rose(prog_data_bus_oe) |-> $past(!oe_s) ##1 !bus_drive_valid_n)
    else $error("bus driven without output enable or valid");
  AST_RELEASE: assert property (
    (prog_data_bus_oe && oe_s) |=> !prog_data_bus_oe && bus_drive_valid_n)
    else $error("bus not released on output enable high");
  AST_ADDR_STEP: assert property (
    (push_ok && s_q.sel == FIELD_DATA && is_stream_cmd(s_q.cmd)) |=>
    s_q.addr == $past(s_q.addr) + ADDRESS_STEP)
    else $error("address pointer did not advance");
  AST_SYNC_DELAY: assert property (
    strobe_s == $past(cmd_strobe_n, 2))
    else $error("strobe synchronizer depth wrong");
  AST_PINS_INPUT: assert property (
    !prog_mode |-> !port_ready_oe && !bus_drive_valid_n_oe &&
    !prog_data_bus_oe)
    else $error("pin driven outside programming mode");
  AST_CLOCK_FROZEN: assert property (
    s_q.clk_locked |=> $stable(ext_clock_select))
    else $error("clock choice changed after first ready drop");
  AST_IGNORE_FIELD: assert property (
    (s_q.st == ST_IDLE && prog_mode && !strobe_s && field_select == 4'h7)
    |=> $stable(s_q.addr) && $stable(s_q.cmd) && s_q.st == ST_WAIT_HI)
    else $error("unselected field touched a register");

  COV_WRITE: cover property (push_ok && s_q.sel == FIELD_DATA);
  COV_READ: cover property ($fell(bus_drive_valid_n));
  COV_FULL: cover property (s_q.st == ST_PUSH && !fifo_in_ready);
  COV_EXT: cover property ($rose(ext_clock_select));
endmodule

`default_nettype wire

// ---- src/ffpi_pkg.sv ----
// Shared constants and carrier types for the parallel flash programming port.
// Assumes a single 200 MHz core clock; pins sampled as synchronous inputs.
package ffpi_pkg;

  // Field selector codes
  localparam logic [3:0] FIELD_COMMAND      = 4'h0;
  localparam logic [3:0] FIELD_ADDRESS_LOW  = 4'h1;
  localparam logic [3:0] FIELD_ADDRESS_NEXT = 4'h2;
  localparam logic [3:0] FIELD_DATA         = 4'h5;

  // Command codes
  localparam logic [15:0] READ_FLASH_CMD            = 16'h0011;
  localparam logic [15:0] WRITE_PAGE_CMD            = 16'h0012;
  localparam logic [15:0] WRITE_PAGE_LOCK_CMD       = 16'h0022;
  localparam logic [15:0] ERASE_WRITE_PAGE_CMD      = 16'h0032;
  localparam logic [15:0] ERASE_WRITE_PAGE_LOCK_CMD = 16'h0042;
  localparam logic [15:0] ERASE_ALL_CMD             = 16'h0013;
  localparam logic [15:0] SET_LOCK_BITS_CMD         = 16'h0014;
  localparam logic [15:0] CLEAR_LOCK_BITS_CMD       = 16'h0024;
  localparam logic [15:0] GET_LOCK_BITS_CMD         = 16'h0015;
  localparam logic [15:0] SET_GP_NVM_CMD            = 16'h0034;
  localparam logic [15:0] CLEAR_GP_NVM_CMD          = 16'h0044;
  localparam logic [15:0] GET_GP_NVM_CMD            = 16'h0025;
  localparam logic [15:0] SET_SECURITY_CMD          = 16'h0054;
  localparam logic [15:0] GET_SECURITY_CMD          = 16'h0035;
  localparam logic [15:0] WRITE_MEMORY_CMD          = 16'h001f;
  localparam logic [15:0] SELECT_CONTROLLER_CMD     = 16'h0016;
  localparam logic [15:0] GET_VERSION_CMD           = 16'h001e;

  // Address handling
  localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDRESS_STEP  = 32'h0000_0002;
  localparam int          ADDR_LOW_LSB  = 0;
  localparam int          ADDR_NEXT_LSB = 16;

  // Timing: slowest external clock accepted is 32 kHz
  localparam int CLOCK_PERIOD_PS     = 5000;
  localparam int EXT_MIN_FREQ_KHZ    = 32;
  localparam int EXT_MAX_PERIOD_PS   = 1000000000 / EXT_MIN_FREQ_KHZ;
  localparam int EXT_DETECT_CYCLES   = EXT_MAX_PERIOD_PS / CLOCK_PERIOD_PS;
  localparam int FIFO_DEPTH          = 4;

  // Request handed to the flash executor
  typedef struct packed {
    logic [3:0]  field;
    logic [15:0] cmd;
    logic [31:0] addr;
    logic [15:0] data;
  } req_s;

  // Handshake states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_PUSH    = 6'b000010,
    ST_RD_DATA = 6'b000100,
    ST_RD_OE   = 6'b001000,
    ST_RD_DRV  = 6'b010000,
    ST_WAIT_HI = 6'b100000
  } hs_state_e;

endpackage

// ---- test/ffpi_programmer.sv ----
// Gang programmer model driving the port's handshake pins through tasks.
// Assumes pull-ups on every pin that it or the device has released.
`timescale 1ns/1ps
`default_nettype none
module ffpi_programmer (
  // Clock
  input  wire logic        clock,
  // Device pins
  input  wire logic        port_ready,
  input  wire logic        bus_drive_valid_n,
  input  wire logic [15:0] prog_data_bus_out,
  input  wire logic        prog_data_bus_oe,
  // Programmer pins
  output logic             cmd_strobe_n,
  output logic             read_out_enable_n,
  output wire logic [3:0]  field_select,
  output wire logic [15:0] prog_data_bus_in
);
  logic        drive_en = 1'b0;
  logic        mode_en  = 1'b0;
  logic [3:0]  mode_val = 4'h0;
  logic [15:0] data_val = 16'h0000;
  int          hang_cnt = 0;

  // Released pins float up; the device wins the bus when it drives
  assign field_select     = mode_en ? mode_val : 4'hf;
  assign prog_data_bus_in = prog_data_bus_oe ? prog_data_bus_out :
                            drive_en ? data_val : 16'hffff;

  // Strobes idle high
  initial begin
    cmd_strobe_n      = 1'b1;
    read_out_enable_n = 1'b1;
  end

  // Bounded wait at falling edges for ready (0) or valid (1)
  task automatic wait_pin(input int which, input logic want, input int lim);
    int n;
    n = 0;
    while (((which == 0) ? port_ready : bus_drive_valid_n) !== want) begin
      @(negedge clock);
      n++;
      if (n > lim) begin
        hang_cnt++;
        return;
      end
    end
  endtask

  // One write or read handshake
  task automatic hs(input logic [3:0] f, input logic [15:0] d,
                    input bit rd, output logic [15:0] got);
    got = 16'h0000;
    @(negedge clock);
    wait_pin(0, 1'b1, 4000);
    mode_val = f;
    data_val = d;
    mode_en  = 1'b1;
    drive_en = 1'b1;
    @(negedge clock);
    cmd_strobe_n = 1'b0;
    wait_pin(0, 1'b0, 20);
    mode_en  = 1'b0;
    drive_en = 1'b0;
    if (rd) begin
      @(negedge clock);
      read_out_enable_n = 1'b0;
      wait_pin(1, 1'b0, 200);
      got = prog_data_bus_in;
      read_out_enable_n = 1'b1;
      wait_pin(1, 1'b1, 100);
    end
    cmd_strobe_n = 1'b1;
    wait_pin(0, 1'b1, 4000);
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench: programmer model, executor model and scoreboard.
// Assumes the port and FIFO under src/ and the shared package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module testbench;
  import ffpi_pkg::*;
  localparam logic [15:0] CMDS [17] = '{READ_FLASH_CMD, WRITE_PAGE_CMD,
    WRITE_PAGE_LOCK_CMD, ERASE_WRITE_PAGE_CMD, ERASE_WRITE_PAGE_LOCK_CMD,
    ERASE_ALL_CMD, SET_LOCK_BITS_CMD, CLEAR_LOCK_BITS_CMD, GET_LOCK_BITS_CMD,
    SET_GP_NVM_CMD, CLEAR_GP_NVM_CMD, GET_GP_NVM_CMD, SET_SECURITY_CMD,
    GET_SECURITY_CMD, WRITE_MEMORY_CMD, SELECT_CONTROLLER_CMD,
    GET_VERSION_CMD};
  localparam logic [15:0] GETS [4] = '{GET_LOCK_BITS_CMD, GET_GP_NVM_CMD,
    GET_SECURITY_CMD, GET_VERSION_CMD};
  logic        clock, reset_n, ext_clock_in, stall, straps;
  logic        req_ready = 1'b0;
  logic        rd_valid = 1'b0;
  logic        port_ready_oe, bus_drive_valid_n_oe;
  bit          ext_on = 1'b1;
  bit          rdy;
  logic [15:0] rd_data = 16'h0000;
  wire logic   cmd_strobe_n, read_out_enable_n;
  wire logic [3:0]  field_select;
  wire logic [15:0] prog_data_bus_in;
  logic [15:0] prog_data_bus_out;
  logic        prog_data_bus_oe, port_ready, bus_drive_valid_n;
  logic        ext_clock_select, req_valid;
  req_s        req, pe;
  req_s        exp_q[$];
  bit          cmd_q[$];
  bit          pc;
  logic [31:0] addr_m;
  logic [15:0] cmd_m;
  int          err_total = 0;
  int          n_checks = 0;

  parallel_flash_programming_port #(.EXT_DETECT(16), .DEPTH(FIFO_DEPTH)) uut (
    .clock(clock), .reset_n(reset_n), .test_select(straps),
    .prog_select_a(straps), .prog_select_b(straps), .ext_clock_in(ext_clock_in),
    .cmd_strobe_n(cmd_strobe_n), .read_out_enable_n(read_out_enable_n),
    .field_select(field_select), .prog_data_bus_in(prog_data_bus_in),
    .prog_data_bus_out(prog_data_bus_out), .prog_data_bus_oe(prog_data_bus_oe),
    .port_ready(port_ready), .port_ready_oe(port_ready_oe),
    .bus_drive_valid_n(bus_drive_valid_n),
    .bus_drive_valid_n_oe(bus_drive_valid_n_oe),
    .ext_clock_select(ext_clock_select),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rd_valid(rd_valid), .rd_data(rd_data));

  ffpi_programmer prog (
    .clock(clock), .port_ready(port_ready),
    .bus_drive_valid_n(bus_drive_valid_n),
    .prog_data_bus_out(prog_data_bus_out), .prog_data_bus_oe(prog_data_bus_oe),
    .cmd_strobe_n(cmd_strobe_n), .read_out_enable_n(read_out_enable_n),
    .field_select(field_select), .prog_data_bus_in(prog_data_bus_in));

  // Core clock and a fast external clock, unrelated in phase
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    ext_clock_in = 1'b0;
    forever #10.3 ext_clock_in = ext_on & ~ext_clock_in;
  end

  // Executor stalls at random; answers a read word as it takes the request
  always @(negedge clock) begin
    rdy = !stall && ($urandom % 4 != 0);
    req_ready <= rdy;
    rd_valid  <= rdy && req_valid === 1'b1 && req.field == FIELD_DATA &&
                 (req.cmd inside {READ_FLASH_CMD, GET_LOCK_BITS_CMD,
                  GET_GP_NVM_CMD, GET_SECURITY_CMD, GET_VERSION_CMD});
  end

  // Scoreboard: every accepted request against the model's queue
  always @(posedge clock) begin
    if (reset_n && req_valid === 1'b1 && req_ready === 1'b1) begin
      `CHK("req_expected", 1'b1, exp_q.size() != 0)
      if (exp_q.size() != 0) begin
        pe = exp_q.pop_front();
        pc = cmd_q.pop_front();
        `CHK("req.field", pe.field, req.field)
        `CHK("req.cmd", pe.cmd, req.cmd)
        if (!pc) begin
          `CHK("req.addr", pe.addr, req.addr)
          `CHK("req.data", pe.data, req.data)
        end
      end
    end
  end

  // Model one handshake, then run it through the programmer
  task automatic do_hs(input logic [3:0] f, input logic [15:0] d, input bit rd);
    req_s r;
    logic [15:0] got;
    r = '0;
    r.field = f;
    if (f == FIELD_COMMAND) begin
      cmd_m = d;
      r.cmd = d;
      exp_q.push_back(r);
      cmd_q.push_back(1'b1);
    end else if (f == FIELD_ADDRESS_LOW) begin
      addr_m[15:0] = d;
    end else if (f == FIELD_ADDRESS_NEXT) begin
      addr_m[23:16] = d[7:0];
    end else if (f == FIELD_DATA) begin
      r.cmd  = cmd_m;
      r.addr = addr_m;
      r.data = d;
      exp_q.push_back(r);
      cmd_q.push_back(1'b0);
      if (cmd_m inside {READ_FLASH_CMD, WRITE_PAGE_CMD, WRITE_PAGE_LOCK_CMD,
          ERASE_WRITE_PAGE_CMD, ERASE_WRITE_PAGE_LOCK_CMD}) begin
        addr_m = addr_m + ADDRESS_STEP;
      end
    end
    prog.hs(f, d, rd, got);
    if (rd) begin
      `CHK("read_data", rd_data, got)
      `CHK("bus_released", 1'b0, prog_data_bus_oe)
    end
  endtask

  // Print counts and verdict, then stop
  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    err_total++;
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(4694));
    reset_n = 1'b0;
    stall   = 1'b0;
    straps  = 1'b1;
    addr_m  = ADDRESS_RESET;
    cmd_m   = 16'h0000;
    repeat (10) @(negedge clock);
    `CHK("data_oe_reset", 1'b0, prog_data_bus_oe)
    `CHK("valid_n_reset", 1'b1, bus_drive_valid_n)
    `CHK("ready_oe_reset", 1'b0, port_ready_oe)
    reset_n = 1'b1;
    repeat (20) @(negedge clock);
    foreach (CMDS[i]) do_hs(FIELD_COMMAND, CMDS[i], 1'b0);
    `CHK("ext_clock_select", 1'b1, ext_clock_select)
    // Page write with chained data words
    do_hs(FIELD_COMMAND, WRITE_PAGE_CMD, 1'b0);
    do_hs(FIELD_ADDRESS_LOW, 16'($urandom), 1'b0);
    do_hs(FIELD_ADDRESS_NEXT, 16'($urandom), 1'b0);
    repeat (3) do_hs(FIELD_DATA, 16'($urandom), 1'b0);
    do_hs(4'h7, 16'h1234, 1'b0);
    // Fill the FIFO, then hold the next handshake off
    while (req_valid !== 1'b0) @(negedge clock);
    @(posedge clock) stall = 1'b1;
    repeat (FIFO_DEPTH) do_hs(FIELD_DATA, 16'($urandom), 1'b0);
    fork
      do_hs(FIELD_DATA, 16'($urandom), 1'b0);
      begin
        repeat (40) @(negedge clock);
        `CHK("ready_held_full", 1'b0, port_ready)
        @(posedge clock) stall = 1'b0;
      end
    join
    // Chained reads
    do_hs(FIELD_COMMAND, READ_FLASH_CMD, 1'b0);
    do_hs(FIELD_ADDRESS_LOW, 16'h0100, 1'b0);
    do_hs(FIELD_ADDRESS_NEXT, 16'h0003, 1'b0);
    repeat (2) begin
      rd_data = 16'($urandom);
      do_hs(FIELD_DATA, 16'hffff, 1'b1);
    end
    // One read under every getter command
    foreach (GETS[i]) begin
      do_hs(FIELD_COMMAND, GETS[i], 1'b0);
      rd_data = 16'($urandom);
      do_hs(FIELD_DATA, 16'hffff, 1'b1);
    end
    repeat (20) @(negedge clock);
    `CHK("queue_drained", 0, exp_q.size())
    // Straps low: ready and valid pins stay inputs
    straps = 1'b0;
    @(negedge clock);
    `CHK("ready_oe_no_mode", 1'b0, port_ready_oe)
    `CHK("valid_oe_no_mode", 1'b0, bus_drive_valid_n_oe)
    // Second reset with the external clock pin held low
    ext_on  = 1'b0;
    reset_n = 1'b0;
    straps  = 1'b1;
    addr_m  = ADDRESS_RESET;
    repeat (10) @(negedge clock);
    `CHK("ready_oe_reset2", 1'b0, port_ready_oe)
    reset_n = 1'b1;
    repeat (20) @(negedge clock);
    do_hs(FIELD_COMMAND, ERASE_ALL_CMD, 1'b0);
    do_hs(FIELD_DATA, 16'h0000, 1'b0);
    `CHK("ext_clock_ignored", 1'b0, ext_clock_select)
    repeat (20) @(negedge clock);
    `CHK("queue_drained_2", 0, exp_q.size())
    `CHK("handshake_hangs", 0, prog.hang_cnt)
    final_report();
  end
endmodule
`default_nettype wire
